// [rtl/txhc_top.sv]
// Transmit control and hardware configuration registers over APB
`timescale 1ns/1ps
module txhc_top
#(
	parameter int TIMEOUT_CYC = txhc_pkg::SOFT_RESET_REQUEST_TIMEOUT_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crossoverStrap,
	input wire logic phyClocksRunning,
	input wire logic frameActive,
	input wire logic txStatusFull,
	output logic txSendAllowed,
	output logic txStatusFullIrq,
	output logic txStatusClear,
	output logic txDataClear,
	output logic portAccessBigEndian,
	output logic directAccessBigEndian,
	output logic mustBeOne,
	output logic softResetActive,
	output logic [15:0] txDataBytes,
	output logic [15:0] txStatBytes,
	output logic [15:0] rxDataBytes,
	output logic [15:0] rxStatBytes
);
	logic rstMeta_ff;
	logic rstSync_ff;
	logic rdyOut_ff;
	logic errOut_ff;
	logic [31:0] rdOut_ff;
	logic txStatusClear_ff;
	logic txDataClear_ff;
	logic overrunPermit_ff;
	logic txEnable_ff;
	logic haltReq_ff;
	logic sendAllowed_ff;
	logic statusIrq_ff;
	logic portOrder_ff;
	logic directOrder_ff;
	logic strapState_ff;
	logic strapTaken_ff;
	logic mustBeOne_ff;
	logic [3:0] txSize_ff;
	logic srTimeout_ff;
	logic softReset_ff;
	logic [15:0] srCount_ff;
	txhc_pkg::txhc_tx_e txState_ff;
	txhc_pkg::txhc_sr_e srState_ff;
	logic access;
	logic wrAccess;
	logic hitTx;
	logic hitHw;
	logic wrTx;
	logic wrHw;
	logic txStopped;
	logic softResetPulse;
	logic [31:0] nxt_rdData;

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end
		else
		begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	assign access = psel && penable;
	assign wrAccess = access && pwrite;
	assign hitTx = paddr == txhc_pkg::TRANSMIT_CONFIG_OFS;
	assign hitHw = paddr == txhc_pkg::HARDWARE_CONFIG_OFS;
	assign wrTx = wrAccess && hitTx && rdyOut_ff;
	assign wrHw = wrAccess && hitHw && rdyOut_ff;
	assign txStopped = txState_ff == txhc_pkg::TXHC_TX_OFF;
	// Soft reset internal phase clears non-immune state
	assign softResetPulse = srState_ff == txhc_pkg::TXHC_SR_HOLD;

	// APB answer: no wait state, error on unmapped
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			rdyOut_ff <= 1'b0;
			errOut_ff <= 1'b0;
			rdOut_ff <= 32'h0000_0000;
		end
		else
		begin
			rdyOut_ff <= psel && !penable;
			errOut_ff <= psel && !penable && !(hitTx || hitHw);
			rdOut_ff <= (psel && !penable && !pwrite) ? nxt_rdData : 32'h0000_0000;
		end
	end

	always_comb
	begin
		nxt_rdData = 32'h0000_0000;
		if (hitTx)
		begin
			nxt_rdData[txhc_pkg::STATUS_OVERRUN_PERMIT_BIT] = overrunPermit_ff;
			nxt_rdData[txhc_pkg::TX_ENABLE_BIT] = txEnable_ff;
			nxt_rdData[txhc_pkg::HALT_REQUEST_BIT] = haltReq_ff;
		end
		else if (hitHw)
		begin
			nxt_rdData[txhc_pkg::PORT_ACCESS_BYTE_ORDER_BIT] = portOrder_ff;
			nxt_rdData[txhc_pkg::DIRECT_ACCESS_BYTE_ORDER_BIT] = directOrder_ff;
			nxt_rdData[txhc_pkg::CROSSOVER_STRAP_STATE_BIT] = strapState_ff;
			nxt_rdData[txhc_pkg::MUST_BE_ONE_BIT] = mustBeOne_ff;
			nxt_rdData[txhc_pkg::TX_SIZE_MSB:txhc_pkg::TX_SIZE_LSB] = txSize_ff;
			nxt_rdData[txhc_pkg::SOFT_RESET_TIMEOUT_BIT] = srTimeout_ff;
			nxt_rdData[txhc_pkg::SOFT_RESET_REQUEST_BIT] = softReset_ff;
		end
	end

	// Discard strobes, one cycle per write, held high through the soft reset hold phase
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			txStatusClear_ff <= 1'b0;
			txDataClear_ff <= 1'b0;
		end
		else
		begin
			txStatusClear_ff <= (wrTx && pwdata[txhc_pkg::XMIT_STATUS_DISCARD_BIT])
				|| softResetPulse;
			txDataClear_ff <= (wrTx && pwdata[txhc_pkg::XMIT_DATA_DISCARD_BIT])
				|| softResetPulse;
		end
	end

	// Transmit control bits and state
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			overrunPermit_ff <= 1'b0;
			txEnable_ff <= 1'b0;
			haltReq_ff <= 1'b0;
			txState_ff <= txhc_pkg::TXHC_TX_OFF;
		end
		else if (softResetPulse)
		begin
			overrunPermit_ff <= 1'b0;
			txEnable_ff <= 1'b0;
			haltReq_ff <= 1'b0;
			txState_ff <= txhc_pkg::TXHC_TX_OFF;
		end
		else
		begin
			if (wrTx)
			begin
				overrunPermit_ff <= pwdata[txhc_pkg::STATUS_OVERRUN_PERMIT_BIT];
			end
			unique case (txState_ff)
				txhc_pkg::TXHC_TX_OFF:
				begin
					if (wrTx && pwdata[txhc_pkg::TX_ENABLE_BIT])
					begin
						txEnable_ff <= 1'b1;
						txState_ff <= txhc_pkg::TXHC_TX_RUN;
					end
				end
				txhc_pkg::TXHC_TX_RUN:
				begin
					if (wrTx)
					begin
						txEnable_ff <= pwdata[txhc_pkg::TX_ENABLE_BIT];
					end
					if (wrTx && pwdata[txhc_pkg::HALT_REQUEST_BIT])
					begin
						haltReq_ff <= 1'b1;
						txState_ff <= txhc_pkg::TXHC_TX_DRAIN;
					end
					else if (wrTx && !pwdata[txhc_pkg::TX_ENABLE_BIT] && !frameActive)
					begin
						txState_ff <= txhc_pkg::TXHC_TX_OFF;
					end
					// Disabled mid-frame: stop once the frame ends
					else if (!txEnable_ff && !frameActive)
					begin
						txState_ff <= txhc_pkg::TXHC_TX_OFF;
					end
				end
				txhc_pkg::TXHC_TX_DRAIN:
				begin
					// Halt bit writes ignored while high
					if (!frameActive)
					begin
						txEnable_ff <= 1'b0;
						haltReq_ff <= 1'b0;
						txState_ff <= txhc_pkg::TXHC_TX_OFF;
					end
				end
				default:
				begin
					txState_ff <= txhc_pkg::TXHC_TX_OFF;
				end
			endcase
		end
	end

	// Send gate and status-full interrupt
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			sendAllowed_ff <= 1'b0;
			statusIrq_ff <= 1'b0;
		end
		else
		begin
			sendAllowed_ff <= !txStopped && txState_ff != txhc_pkg::TXHC_TX_DRAIN
				&& txEnable_ff && (overrunPermit_ff || !txStatusFull);
			statusIrq_ff <= txStatusFull;
		end
	end

	// Byte order bits, immune to soft reset
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			portOrder_ff <= 1'b0;
			directOrder_ff <= 1'b0;
		end
		else if (wrHw)
		begin
			portOrder_ff <= pwdata[txhc_pkg::PORT_ACCESS_BYTE_ORDER_BIT];
			directOrder_ff <= pwdata[txhc_pkg::DIRECT_ACCESS_BYTE_ORDER_BIT];
		end
	end

	// Strap caught after reset release
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			strapState_ff <= 1'b0;
			strapTaken_ff <= 1'b0;
		end
		else if (!strapTaken_ff)
		begin
			strapState_ff <= crossoverStrap;
			strapTaken_ff <= 1'b1;
		end
	end

	// Configuration fields
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			mustBeOne_ff <= 1'b0;
			txSize_ff <= txhc_pkg::TX_SIZE_RESET;
		end
		else if (softResetPulse)
		begin
			mustBeOne_ff <= 1'b0;
			txSize_ff <= txhc_pkg::TX_SIZE_RESET;
		end
		else if (wrHw)
		begin
			mustBeOne_ff <= pwdata[txhc_pkg::MUST_BE_ONE_BIT];
			// Only the valid size range is taken
			if (pwdata[txhc_pkg::TX_SIZE_MSB:txhc_pkg::TX_SIZE_LSB] >= txhc_pkg::TX_SIZE_MIN
				&& pwdata[txhc_pkg::TX_SIZE_MSB:txhc_pkg::TX_SIZE_LSB] <= txhc_pkg::TX_SIZE_MAX)
			begin
				txSize_ff <= pwdata[txhc_pkg::TX_SIZE_MSB:txhc_pkg::TX_SIZE_LSB];
			end
		end
	end

	// Soft reset sequencer
	always_ff @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			softReset_ff <= 1'b0;
			srTimeout_ff <= 1'b0;
			srCount_ff <= 16'h0000;
			srState_ff <= txhc_pkg::TXHC_SR_IDLE;
		end
		else
		begin
			unique case (srState_ff)
				txhc_pkg::TXHC_SR_IDLE:
				begin
					if (wrHw && pwdata[txhc_pkg::SOFT_RESET_REQUEST_BIT])
					begin
						softReset_ff <= 1'b1;
						srTimeout_ff <= 1'b0;
						srCount_ff <= 16'h0000;
						srState_ff <= txhc_pkg::TXHC_SR_WAIT;
					end
				end
				txhc_pkg::TXHC_SR_WAIT:
				begin
					if (phyClocksRunning)
					begin
						srCount_ff <= 16'h0000;
						srState_ff <= txhc_pkg::TXHC_SR_HOLD;
					end
					else if (srCount_ff == 16'(TIMEOUT_CYC - 1))
					begin
						softReset_ff <= 1'b0;
						srTimeout_ff <= 1'b1;
						srState_ff <= txhc_pkg::TXHC_SR_IDLE;
					end
					else
					begin
						srCount_ff <= srCount_ff + 16'h0001;
					end
				end
				txhc_pkg::TXHC_SR_HOLD:
				begin
					if (srCount_ff == 16'(txhc_pkg::SOFT_RESET_REQUEST_HOLD_CYC - 1))
					begin
						softReset_ff <= 1'b0;
						srState_ff <= txhc_pkg::TXHC_SR_IDLE;
					end
					else
					begin
						srCount_ff <= srCount_ff + 16'h0001;
					end
				end
				default:
				begin
					srState_ff <= txhc_pkg::TXHC_SR_IDLE;
				end
			endcase
		end
	end

	txhc_alloc u_alloc
	(
		.sys_clk(sys_clk),
		.rstSync_n(rstSync_ff),
		.txSize(txSize_ff),
		.txDataBytes_ff(txDataBytes),
		.txStatBytes_ff(txStatBytes),
		.rxDataBytes_ff(rxDataBytes),
		.rxStatBytes_ff(rxStatBytes)
	);

	assign prdata = rdOut_ff;
	assign pready = rdyOut_ff;
	assign pslverr = errOut_ff;
	assign txSendAllowed = sendAllowed_ff;
	assign txStatusFullIrq = statusIrq_ff;
	assign txStatusClear = txStatusClear_ff;
	assign txDataClear = txDataClear_ff;
	assign portAccessBigEndian = portOrder_ff;
	assign directAccessBigEndian = directOrder_ff;
	assign mustBeOne = mustBeOne_ff;
	assign softResetActive = softReset_ff;
endmodule

// [rtl/txhc_pkg.sv]
// Package with register map, fields, reset values and timing counts
package txhc_pkg;
	localparam logic [7:0] TRANSMIT_CONFIG_OFS = 8'h70;
	localparam logic [7:0] HARDWARE_CONFIG_OFS = 8'h74;
	localparam int XMIT_STATUS_DISCARD_BIT = 15;
	localparam int XMIT_DATA_DISCARD_BIT = 14;
	localparam int STATUS_OVERRUN_PERMIT_BIT = 2;
	localparam int TX_ENABLE_BIT = 1;
	localparam int HALT_REQUEST_BIT = 0;
	localparam int PORT_ACCESS_BYTE_ORDER_BIT = 29;
	localparam int DIRECT_ACCESS_BYTE_ORDER_BIT = 28;
	localparam int CROSSOVER_STRAP_STATE_BIT = 24;
	localparam int MUST_BE_ONE_BIT = 20;
	localparam int TX_SIZE_LSB = 16;
	localparam int TX_SIZE_MSB = 19;
	localparam int SOFT_RESET_TIMEOUT_BIT = 1;
	localparam int SOFT_RESET_REQUEST_BIT = 0;
	localparam logic [3:0] TX_SIZE_RESET = 4'h5;
	localparam logic [3:0] TX_SIZE_MIN = 4'h2;
	localparam logic [3:0] TX_SIZE_MAX = 4'hE;
	localparam logic [15:0] TOTAL_BYTES = 16'h4000;
	localparam logic [15:0] TX_STATUS_BYTES = 16'h0200;
	localparam int RX_STATUS_SHIFT = 4;
	localparam int SIZE_STEP_SHIFT = 10;
	// Soft reset phase timing
	localparam int SOFT_RESET_REQUEST_HOLD_NS = 500;
	localparam int SOFT_RESET_REQUEST_TIMEOUT_NS = 10000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SOFT_RESET_REQUEST_HOLD_CYC = (SOFT_RESET_REQUEST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SOFT_RESET_REQUEST_TIMEOUT_CYC = SOFT_RESET_REQUEST_TIMEOUT_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0]
	{
		TXHC_TX_OFF = 2'b00,
		TXHC_TX_RUN = 2'b01,
		TXHC_TX_DRAIN = 2'b10
	} txhc_tx_e;
	typedef enum logic [1:0]
	{
		TXHC_SR_IDLE = 2'b00,
		TXHC_SR_WAIT = 2'b01,
		TXHC_SR_HOLD = 2'b10
	} txhc_sr_e;
endpackage

// [rtl/txhc_alloc.sv]
// Buffer split between transmit and receive queues
`timescale 1ns/1ps
module txhc_alloc
(
	input wire logic sys_clk,
	input wire logic rstSync_n,
	input wire logic [3:0] txSize,
	output logic [15:0] txDataBytes_ff,
	output logic [15:0] txStatBytes_ff,
	output logic [15:0] rxDataBytes_ff,
	output logic [15:0] rxStatBytes_ff
);
	logic [15:0] txTotal;
	logic [15:0] rxTotal;
	logic [15:0] rxStat;
	assign txTotal = {2'b00, txSize, 10'h000};
	assign rxTotal = txhc_pkg::TOTAL_BYTES - txTotal;
	assign rxStat = rxTotal >> txhc_pkg::RX_STATUS_SHIFT;
	always_ff @(posedge sys_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			txDataBytes_ff <= 16'h0000;
			txStatBytes_ff <= 16'h0000;
			rxDataBytes_ff <= 16'h0000;
			rxStatBytes_ff <= 16'h0000;
		end
		else
		begin
			txStatBytes_ff <= txhc_pkg::TX_STATUS_BYTES;
			txDataBytes_ff <= txTotal - txhc_pkg::TX_STATUS_BYTES;
			rxStatBytes_ff <= rxStat;
			rxDataBytes_ff <= rxTotal - rxStat;
		end
	end
endmodule

// [testbench/txhc_asserts.sv]
// Concurrent checks on the transmit and hardware config block
`timescale 1ns/1ps
module txhc_asserts
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txStatusFull,
	input wire logic txStatusFullIrq,
	input wire logic txStatusClear,
	input wire logic txDataClear,
	input wire logic portAccessBigEndian,
	input wire logic mustBeOne,
	input wire logic softResetActive,
	input wire logic [15:0] txDataBytes,
	input wire logic [15:0] txStatBytes,
	input wire logic [15:0] rxDataBytes,
	input wire logic [15:0] rxStatBytes
);
	logic [3:0] upSh_ff;
	logic live;
	logic wr;
	// Outputs settle three edges after reset release; checks start after the fourth
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			upSh_ff <= 4'h0;
		else
			upSh_ff <= {upSh_ff[2:0], 1'b1};
	end
	assign live = upSh_ff[3];
	assign wr = psel && penable && pready && pwrite;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	stat_discard_a:
		assert property (wr && paddr == 8'h70 && pwdata[15] |=> txStatusClear)
		else $error("status discard strobe missing");
	data_discard_a:
		assert property (wr && paddr == 8'h70 && pwdata[14] |=> txDataClear)
		else $error("data discard strobe missing");
	irq_tracks_full_a:
		assert property (live && !softResetActive |=> txStatusFullIrq == $past(txStatusFull))
		else $error("status full irq mismatch");
	port_order_a:
		assert property (wr && paddr == 8'h74 |=> portAccessBigEndian == $past(pwdata[29]))
		else $error("port byte order not written");
	must_one_a:
		assert property (wr && paddr == 8'h74 && !pwdata[0] |=> mustBeOne == $past(pwdata[20]))
		else $error("must be one bit not written");
	stat_share_a:
		assert property (live |-> txStatBytes == 16'h0200)
		else $error("status share wrong");
	total_split_a:
		assert property (live |-> txDataBytes + txStatBytes + rxDataBytes + rxStatBytes == 16'h4000)
		else $error("split does not total");
	rx_sixteenth_a:
		assert property (live |-> {rxStatBytes, 4'h0} == rxDataBytes + rxStatBytes)
		else $error("receive status share wrong");
	soft_start_a:
		assert property (wr && paddr == 8'h74 && pwdata[0] |=> softResetActive)
		else $error("soft reset not started");
	unmapped_err_a:
		assert property (psel && !penable && paddr != 8'h70 && paddr != 8'h74 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule
bind txhc_top txhc_asserts u_txhc_asserts
(
	.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.txStatusFull, .txStatusFullIrq, .txStatusClear, .txDataClear, .portAccessBigEndian,
	.mustBeOne, .softResetActive, .txDataBytes, .txStatBytes, .rxDataBytes, .rxStatBytes
);

// [testbench/txhc_xmit_model.sv]
// Transmitter and status queue model on the far side of the controls
`timescale 1ns/1ps
module txhc_xmit_model
#(
	parameter int FRAME_CYC = 30,
	parameter int STAT_DEPTH = 3
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic phyOn,
	input wire logic txSendAllowed,
	input wire logic txStatusClear,
	output logic frameActive,
	output logic txStatusFull,
	output logic phyClocksRunning
);
	logic [7:0] cnt_ff;
	logic [3:0] stat_ff;
	// A started frame always runs to its end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_ff <= 8'h0;
		else if (cnt_ff != 8'h0)
			cnt_ff <= cnt_ff - 8'h1;
		else if (txSendAllowed)
			cnt_ff <= 8'(FRAME_CYC);
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n || txStatusClear)
			stat_ff <= 4'h0;
		else if (cnt_ff == 8'h1)
			stat_ff <= stat_ff + 4'h1;
	end
	assign frameActive = cnt_ff != 8'h0;
	assign txStatusFull = stat_ff >= 4'(STAT_DEPTH);
	assign phyClocksRunning = phyOn;
endmodule

// [testbench/txhc_top_tb.sv]
// Self-checking bench for the transmit and hardware config block
`timescale 1ns/1ps
module txhc_top_tb;
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, erv, phyOn;
	logic phyClocksRunning, frameActive, txStatusFull, txSendAllowed, txStatusFullIrq;
	logic txStatusClear, portAccessBigEndian, directAccessBigEndian, mustBeOne;
	logic softResetActive, txDataClear, strap;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [15:0] txDataBytes, txStatBytes, rxDataBytes, rxStatBytes;
	int n_mismatch, checks_done, i;
	txhc_top #(.TIMEOUT_CYC(8)) u_txhc_top
	(
		.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .crossoverStrap(strap), .phyClocksRunning, .frameActive, .txStatusFull,
		.txSendAllowed, .txStatusFullIrq, .txStatusClear, .txDataClear,
		.portAccessBigEndian, .directAccessBigEndian, .mustBeOne, .softResetActive,
		.txDataBytes, .txStatBytes, .rxDataBytes, .rxStatBytes
	);
	txhc_xmit_model u_txhc_xmit_model
	(
		.sys_clk, .rst_n, .phyOn, .txSendAllowed, .txStatusClear, .frameActive,
		.txStatusFull, .phyClocksRunning
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Answer taken at the rising edge where pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial
	begin
		#250000;
		n_mismatch++;
		summarize();
	end
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		phyOn = 1'b1;
		strap = 1'b1;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		look(4);
		chk({txDataBytes, rxDataBytes}, {16'h1200, 16'h2940});
		chk({txStatBytes, rxStatBytes}, {16'h0200, 16'h02C0});
		rd(8'h70, 32'h0);
		rd(8'h74, 32'h0105_0000);
		rd(8'h78, 32'h0);
		chk(32'(erv), 32'h1);
		apb(1'b1, 8'h70, 32'hFFFF_3FF8);
		rd(8'h70, 32'h0);
		// Transmitter is off while the config is rewritten
		for (int s = 2; s < 15; s++)
		begin
			int r;
			r = 32'h4000 - (s << 10);
			apb(1'b1, 8'h74, 32'hCEF0_FFFE | 32'(s) << 16 | 32'(s & 3) << 28);
			rd(8'h74, 32'h0110_0000 | 32'(s) << 16 | 32'(s & 3) << 28);
			look(1);
			chk({txDataBytes, rxStatBytes}, {16'((s << 10) - 32'h200), 16'(r >> 4)});
			chk({rxDataBytes, 13'h0, portAccessBigEndian, directAccessBigEndian, mustBeOne},
				{16'(r - (r >> 4)), 13'h0, 2'(s & 3), 1'b1});
		end
		apb(1'b1, 8'h74, 32'h001F_0000);
		rd(8'h74, 32'h011E_0000);
		apb(1'b1, 8'h74, 32'h0011_0000);
		rd(8'h74, 32'h011E_0000);
		apb(1'b1, 8'h70, 32'h2);
		look(2);
		chk(32'(txSendAllowed), 32'h1);
		for (i = 0; i < 400 && txStatusFull !== 1'b1; i++) look(0);
		for (i = 0; i < 60 && frameActive !== 1'b0; i++) look(0);
		look(2);
		chk(32'({txSendAllowed, txStatusFullIrq}), 32'h1);
		apb(1'b1, 8'h70, 32'h6);
		look(2);
		chk(32'({txSendAllowed, txStatusFullIrq}), 32'h3);
		apb(1'b1, 8'h70, 32'h8006);
		look(2);
		chk(32'({txStatusFull, txStatusFullIrq}), 32'h0);
		rd(8'h70, 32'h6);
		apb(1'b1, 8'h70, 32'h4006);
		look(0);
		chk(32'(txDataClear), 32'h1);
		rd(8'h70, 32'h6);
		for (i = 0; i < 60 && frameActive !== 1'b0; i++) look(0);
		for (i = 0; i < 60 && frameActive !== 1'b1; i++) look(0);
		apb(1'b1, 8'h70, 32'h7);
		rd(8'h70, 32'h7);
		apb(1'b1, 8'h70, 32'h6);
		rd(8'h70, 32'h7);
		for (i = 0; i < 60 && frameActive !== 1'b0; i++) look(0);
		look(2);
		rd(8'h70, 32'h4);
		apb(1'b1, 8'h74, 32'h3019_0000);
		apb(1'b1, 8'h74, 32'h3019_0001);
		look(1);
		chk(32'(softResetActive), 32'h1);
		look(20);
		rd(8'h74, 32'h3105_0000);
		rd(8'h70, 32'h0);
		phyOn <= 1'b0;
		apb(1'b1, 8'h74, 32'h0010_0001);
		look(14);
		chk(32'(softResetActive), 32'h0);
		rd(8'h74, 32'h0115_0002);
		phyOn <= 1'b1;
		apb(1'b1, 8'h74, 32'h0010_0001);
		look(20);
		rd(8'h74, 32'h0105_0000);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		strap <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		look(4);
		rd(8'h74, 32'h0005_0000);
		summarize();
	end
endmodule
